/* dbi_pkg.sv */
// Package: register map, field layout and reset values of the DAC board interrupt block
package dbi_pkg;
  localparam int NUM_FIFO = 32;
  localparam int NUM_QDAC = 8;
  localparam int OC_BITS = 4;
  localparam int ADDR_W = 8;
  localparam int TMR_W = 16;

  typedef enum logic [1:0] {
    DBI_MODE_IMM = 2'b00,
    DBI_MODE_MEM = 2'b01,
    DBI_MODE_FIFO = 2'b10,
    DBI_MODE_SEQ = 2'b11
  } dbi_mode_t;

  // Byte offsets
  localparam logic [7:0] CTRL_BASE = 8'h00;
  localparam logic [7:0] FIFO_IRQ_EN_OFS = 8'h20;
  localparam logic [7:0] FIFO_IRQ_STAT_OFS = 8'h24;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h28;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h2c;
  localparam logic [7:0] AUTO_PERIOD_OFS = 8'h30;

  // Quad control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SEQ_EN = 2;
  localparam int CTRL_LOAD_EN = 3;
  localparam int CTRL_ALERT_EN = 4;
  localparam int CTRL_AUTO_EN = 5;
  localparam int CTRL_W = 6;

  // Interrupt status and mask layout
  localparam int STAT_SEQ_LSB = 0;
  localparam int STAT_LOAD_LSB = 8;
  localparam int STAT_ALERT_LSB = 16;
  localparam int STAT_FIFO_BIT = 24;

  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [31:0] FIFO_IRQ_EN_RST = 32'h0000_0000;
  localparam logic [31:0] IRQ_MASK_RST = 32'h0000_0000;
  localparam logic [TMR_W-1:0] AUTO_PERIOD_RST = 16'h1000;
endpackage

/* dbi_irq.sv */
// DAC board interrupt collector with APB register file and status-read request logic
// How it works
// - One combined FIFO flag covers every FIFO, up to 32, whose own interrupt enable is set.
// - The FIFO flag is set while any enabled FIFO is below its limit or holds no samples.
// - The FIFO flag clears itself, with no acknowledge, once all enabled FIFOs are above limit.
// - A per-FIFO status word shows which enabled channels are raising the FIFO flag.
// - Each quad DAC has a sequencer flag, set when enabled and its sequencer asks for new data in sequencer mode.
// - Each quad DAC has a load flag, set when enabled and its outputs update in memory mode.
// - Each quad DAC has an alert flag, set when enabled and a status read shows an alert bit.
// - In FIFO and sequencer modes one converter status read is requested per sequence.
// - In immediate and memory modes a status read is requested each time the auto timer expires.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dbi_irq (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] fifo_below_limit,
  input wire logic [31:0] fifo_empty,
  input wire logic [7:0] seq_data_request,
  input wire logic [7:0] seq_cycle_start,
  input wire logic [7:0] mem_load_done,
  input wire logic [7:0] status_read_done,
  input wire logic [31:0] status_overcurrent,
  input wire logic [7:0] status_thermal,
  output logic [7:0] status_read_req,
  output logic irq
);
  localparam int NQ = dbi_pkg::NUM_QDAC;

  logic [dbi_pkg::CTRL_W-1:0] ctrl_q [NQ];
  logic [31:0] fifo_en_q;
  logic [31:0] fifo_stat_q;
  logic fifo_level_irq_q;
  logic [NQ-1:0] sequencer_request_irq_q;
  logic [NQ-1:0] output_loaded_irq_q;
  logic [NQ-1:0] converter_alert_irq_q;
  logic [31:0] irq_mask_q;
  logic [dbi_pkg::TMR_W-1:0] auto_period_q;
  logic [NQ-1:0] seq_set, load_set, alert_set, req_d;
  logic [NQ-1:0] seq_clr, load_clr, alert_clr;
  logic [NQ-1:0] status_read_req_q;
  logic [31:0] irq_stat;
  logic [31:0] prdata_q, rdata_d;
  logic pready_q, pslverr_q, irq_q;
  logic acc_done, wr_en, addr_ok;
  logic [5:0] widx;
  logic [31:0] fifo_hit;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign status_read_req = status_read_req_q;

  // APB: one wait state, so every access answers in its second access cycle
  assign acc_done = psel && penable && pready_q;
  assign wr_en = acc_done && pwrite && addr_ok;
  assign widx = paddr[7:2];

  always_comb begin
    addr_ok = 1'b1;
    rdata_d = 32'h0000_0000;
    if (paddr[1:0] != 2'b00) begin
      addr_ok = 1'b0;
    end else if (paddr < dbi_pkg::FIFO_IRQ_EN_OFS) begin
      rdata_d = {26'h0, ctrl_q[widx[2:0]]};
    end else begin
      unique case (paddr)
        dbi_pkg::FIFO_IRQ_EN_OFS: rdata_d = fifo_en_q;
        dbi_pkg::FIFO_IRQ_STAT_OFS: rdata_d = fifo_stat_q;
        dbi_pkg::IRQ_STAT_OFS: rdata_d = irq_stat;
        dbi_pkg::IRQ_MASK_OFS: rdata_d = irq_mask_q;
        dbi_pkg::AUTO_PERIOD_OFS: rdata_d = {16'h0, auto_period_q};
        default: addr_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !addr_ok;
      if (psel && penable && !pready_q) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < NQ; i++) begin
        ctrl_q[i] <= dbi_pkg::CTRL_RST;
      end
      fifo_en_q <= dbi_pkg::FIFO_IRQ_EN_RST;
      irq_mask_q <= dbi_pkg::IRQ_MASK_RST;
      auto_period_q <= dbi_pkg::AUTO_PERIOD_RST;
    end else if (wr_en) begin
      if (paddr < dbi_pkg::FIFO_IRQ_EN_OFS) begin
        ctrl_q[widx[2:0]] <= pwdata[dbi_pkg::CTRL_W-1:0];
      end
      if (paddr == dbi_pkg::FIFO_IRQ_EN_OFS) begin
        fifo_en_q <= pwdata;
      end
      if (paddr == dbi_pkg::IRQ_MASK_OFS) begin
        irq_mask_q <= pwdata;
      end
      if (paddr == dbi_pkg::AUTO_PERIOD_OFS) begin
        auto_period_q <= pwdata[dbi_pkg::TMR_W-1:0];
      end
    end
  end

  // FIFO source is a level: it follows the FIFOs, no acknowledge exists
  assign fifo_hit = fifo_en_q & (fifo_below_limit | fifo_empty);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fifo_stat_q <= 32'h0000_0000;
      fifo_level_irq_q <= 1'b0;
    end else begin
      fifo_stat_q <= fifo_hit;
      fifo_level_irq_q <= |fifo_hit;
    end
  end

  // Per-quad sources and status-read requests
  for (genvar q = 0; q < NQ; q++) begin : g_quad
    dbi_pkg::dbi_mode_t mode;
    logic [dbi_pkg::TMR_W-1:0] tmr_q;
    logic auto_ok, expire;
    assign mode = dbi_pkg::dbi_mode_t'(ctrl_q[q][dbi_pkg::CTRL_MODE_LSB +: 2]);
    assign seq_set[q] = seq_data_request[q] && ctrl_q[q][dbi_pkg::CTRL_SEQ_EN]
                        && mode == dbi_pkg::DBI_MODE_SEQ;
    assign load_set[q] = mem_load_done[q] && ctrl_q[q][dbi_pkg::CTRL_LOAD_EN]
                         && mode == dbi_pkg::DBI_MODE_MEM;
    assign alert_set[q] = status_read_done[q] && ctrl_q[q][dbi_pkg::CTRL_ALERT_EN]
                          && (|status_overcurrent[4*q +: 4] || status_thermal[q]);
    assign auto_ok = ctrl_q[q][dbi_pkg::CTRL_AUTO_EN]
                     && (mode == dbi_pkg::DBI_MODE_IMM || mode == dbi_pkg::DBI_MODE_MEM);
    assign expire = auto_ok && tmr_q == '0;
    // Sequenced modes read once per sequence; timed reads only in the direct modes
    assign req_d[q] = expire
                      || (seq_cycle_start[q] && !auto_ok
                          && (mode == dbi_pkg::DBI_MODE_FIFO || mode == dbi_pkg::DBI_MODE_SEQ));

    // Timer rests at the period while disabled, so the first read comes one period late
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        tmr_q <= dbi_pkg::AUTO_PERIOD_RST;
      end else if (!auto_ok || expire) begin
        tmr_q <= auto_period_q;
      end else begin
        tmr_q <= tmr_q - 16'h0001;
      end
    end

    property p_seq_set;
      @(posedge sys_clk) disable iff (rst)
      seq_set[q] |=> sequencer_request_irq_q[q];
    endproperty
    a_seq_set: assert property (p_seq_set) else $error("sequencer flag not set");

    property p_load_mode;
      @(posedge sys_clk) disable iff (rst)
      mem_load_done[q] && mode != dbi_pkg::DBI_MODE_MEM && !output_loaded_irq_q[q]
      |=> !output_loaded_irq_q[q];
    endproperty
    a_load_mode: assert property (p_load_mode) else $error("load flag set outside memory mode");

    property p_alert_set;
      @(posedge sys_clk) disable iff (rst)
      status_read_done[q] && ctrl_q[q][dbi_pkg::CTRL_ALERT_EN] && status_thermal[q]
      |=> converter_alert_irq_q[q];
    endproperty
    a_alert_set: assert property (p_alert_set) else $error("alert flag not set");

    property p_seq_read;
      @(posedge sys_clk) disable iff (rst)
      seq_cycle_start[q] && mode == dbi_pkg::DBI_MODE_FIFO && !ctrl_q[q][dbi_pkg::CTRL_AUTO_EN]
      |=> status_read_req_q[q];
    endproperty
    a_seq_read: assert property (p_seq_read) else $error("no status read for sequence");

    property p_auto_read;
      @(posedge sys_clk) disable iff (rst)
      auto_ok && tmr_q == 16'h0002 && $stable(ctrl_q[q]) ##1 auto_ok
      |-> ##2 status_read_req_q[q];
    endproperty
    a_auto_read: assert property (p_auto_read) else $error("auto status read missed");
  end

  // Sticky flags, write one to clear; an event in the clearing cycle wins
  assign irq_stat = {7'h00, fifo_level_irq_q, converter_alert_irq_q,
                     output_loaded_irq_q, sequencer_request_irq_q};
  assign seq_clr = (wr_en && paddr == dbi_pkg::IRQ_STAT_OFS) ?
                   pwdata[dbi_pkg::STAT_SEQ_LSB +: 8] : 8'h00;
  assign load_clr = (wr_en && paddr == dbi_pkg::IRQ_STAT_OFS) ?
                    pwdata[dbi_pkg::STAT_LOAD_LSB +: 8] : 8'h00;
  assign alert_clr = (wr_en && paddr == dbi_pkg::IRQ_STAT_OFS) ?
                     pwdata[dbi_pkg::STAT_ALERT_LSB +: 8] : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sequencer_request_irq_q <= 8'h00;
      output_loaded_irq_q <= 8'h00;
      converter_alert_irq_q <= 8'h00;
    end else begin
      sequencer_request_irq_q <= seq_set | (sequencer_request_irq_q & ~seq_clr);
      output_loaded_irq_q <= load_set | (output_loaded_irq_q & ~load_clr);
      converter_alert_irq_q <= alert_set | (converter_alert_irq_q & ~alert_clr);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_read_req_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      status_read_req_q <= req_d;
      irq_q <= |(irq_stat & irq_mask_q);
    end
  end

  property p_fifo_set;
    @(posedge sys_clk) disable iff (rst)
    |(fifo_en_q & fifo_empty) |=> fifo_level_irq_q;
  endproperty
  a_fifo_set: assert property (p_fifo_set) else $error("fifo flag not set");

  property p_fifo_clr;
    @(posedge sys_clk) disable iff (rst)
    (fifo_en_q & (fifo_below_limit | fifo_empty)) == 32'h0000_0000 |=> !fifo_level_irq_q;
  endproperty
  a_fifo_clr: assert property (p_fifo_clr) else $error("fifo flag did not clear");

  property p_fifo_stat;
    @(posedge sys_clk) disable iff (rst)
    1'b1 |=> fifo_stat_q == ($past(fifo_en_q) & $past(fifo_below_limit | fifo_empty));
  endproperty
  a_fifo_stat: assert property (p_fifo_stat) else $error("fifo channel status wrong");

  property p_fifo_disabled;
    @(posedge sys_clk) disable iff (rst)
    fifo_en_q == 32'h0000_0000 |=> !fifo_level_irq_q;
  endproperty
  a_fifo_disabled: assert property (p_fifo_disabled) else $error("disabled fifo raised flag");

  property p_w1c;
    @(posedge sys_clk) disable iff (rst)
    wr_en && paddr == dbi_pkg::IRQ_STAT_OFS && pwdata[0] && !seq_set[0]
    |=> !sequencer_request_irq_q[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

  property p_irq_out;
    @(posedge sys_clk) disable iff (rst)
    (irq_stat & irq_mask_q) != 32'h0000_0000 |=> irq_q;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("interrupt line low with pending flag");

  property p_irq_quiet;
    @(posedge sys_clk) disable iff (rst)
    (irq_stat & irq_mask_q) == 32'h0000_0000 |=> !irq_q;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt line high with no flag");

  property p_apb_answer;
    @(posedge sys_clk) disable iff (rst)
    psel && !penable ##1 psel && penable |=> pready_q;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer not after one wait");
endmodule
`default_nettype wire

/* dbi_host.sv */
// Host model: APB master of the interrupt handler side
`timescale 1ns/1ps
`default_nettype none
module dbi_host (
  input wire logic sys_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Call right after a rising edge; returns one edge after the edge that took the transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Stale data must not look valid once released
    pwdata <= ~d;
    // An idle cycle keeps a following call from driving these signals twice in one step
    @(posedge sys_clk);
  endtask
  // Flags are acknowledged by writing ones
  task automatic ack(input logic [31:0] bits);
    logic [31:0] d;
    logic e;
    xfer(1'b1, dbi_pkg::IRQ_STAT_OFS, bits, d, e);
  endtask
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench for the DAC board interrupt collector
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
  n_checks++; \
  if ((got) !== (ex)) begin \
    errors++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); \
  end \
end
module tb;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0] paddr, seq_data_request, seq_cycle_start, mem_load_done, q8;
  logic [7:0] status_read_done, status_thermal, status_read_req;
  logic [31:0] pwdata, prdata, fifo_below_limit, fifo_empty, status_overcurrent;
  logic [31:0] rd, en, ex;
  int errors, n_checks, cyc, seed, q, gap;
  dbi_irq DUT (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fifo_below_limit(fifo_below_limit), .fifo_empty(fifo_empty),
    .seq_data_request(seq_data_request), .seq_cycle_start(seq_cycle_start),
    .mem_load_done(mem_load_done), .status_read_done(status_read_done),
    .status_overcurrent(status_overcurrent), .status_thermal(status_thermal),
    .status_read_req(status_read_req), .irq(irq));
  dbi_host host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, err);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, rd, err);
    `CHK(nm, e, rd)
  endtask
  // irq trails a flag change by one registered stage
  task automatic irq_chk(input logic e);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("irq", e, irq)
    @(posedge sys_clk);
  endtask
  function automatic logic [31:0] qbit(int lsb, int qq);
    return 32'h1 << (lsb + qq);
  endfunction
  function automatic logic alert_hit(logic [3:0] oc, logic th);
    return (oc != 4'h0) || th;
  endfunction
  initial begin
    seed = 32'h7e8b6d1c;
    rst = 1'b1;
    {seq_data_request, seq_cycle_start, mem_load_done, status_read_done} = '0;
    {status_thermal, fifo_below_limit, fifo_empty, status_overcurrent} = '0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd_chk("ctrl0", dbi_pkg::CTRL_BASE, 32'h0);
    rd_chk("mask", dbi_pkg::IRQ_MASK_OFS, 32'h0);
    rd_chk("period", dbi_pkg::AUTO_PERIOD_OFS, 32'h0000_1000);
    rd_chk("unmapped", 8'h80, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    $display("test reset done");
    wr(dbi_pkg::IRQ_MASK_OFS, 32'h01ff_ffff);
    for (q = 0; q < 8; q++) begin
      wr(dbi_pkg::CTRL_BASE + 8'(4 * q), 32'h1f);
      q8 = 8'h1 << q;
      seq_data_request <= q8;
      mem_load_done <= q8;
      status_read_done <= q8;
      status_overcurrent <= $random(seed);
      status_thermal <= 8'($random(seed));
      @(posedge sys_clk);
      {seq_data_request, mem_load_done, status_read_done} <= '0;
      @(posedge sys_clk);
      ex = qbit(dbi_pkg::STAT_SEQ_LSB, q);
      if (alert_hit(status_overcurrent[4*q+:4], status_thermal[q])) begin
        ex |= qbit(dbi_pkg::STAT_ALERT_LSB, q);
      end
      rd_chk("stat quad", dbi_pkg::IRQ_STAT_OFS, ex);
      irq_chk(1'b1);
      host.ack(ex);
      irq_chk(1'b0);
      rd_chk("stat acked", dbi_pkg::IRQ_STAT_OFS, 32'h0);
    end
    $display("test quads done");
    q = $unsigned($random(seed)) % 8;
    q8 = 8'h1 << q;
    wr(dbi_pkg::AUTO_PERIOD_OFS, 32'h4);
    wr(dbi_pkg::CTRL_BASE + 8'(4 * q), 32'h29);
    mem_load_done <= q8;
    seq_data_request <= q8;
    @(posedge sys_clk);
    {mem_load_done, seq_data_request} <= '0;
    @(posedge sys_clk);
    rd_chk("load", dbi_pkg::IRQ_STAT_OFS, qbit(dbi_pkg::STAT_LOAD_LSB, q));
    host.ack(32'h00ff_ffff);
    while (status_read_req[q] !== 1'b1) @(posedge sys_clk);
    @(posedge sys_clk);
    gap = 1;
    while (status_read_req[q] !== 1'b1) begin
      gap++;
      @(posedge sys_clk);
    end
    `CHK("auto gap", 32'(5), 32'(gap))
    q8 = 8'h1 << ((q + 1) % 8);
    wr(dbi_pkg::CTRL_BASE + 8'(4 * ((q + 1) % 8)), 32'h2);
    seq_cycle_start <= q8;
    @(posedge sys_clk);
    seq_cycle_start <= 8'h0;
    @(negedge sys_clk);
    `CHK("seq read req", q8, status_read_req & q8)
    @(posedge sys_clk);
    wr(dbi_pkg::CTRL_BASE + 8'(4 * q), 32'h20);
    gap = 0;
    while (status_read_req[q] !== 1'b1 && gap < 10) begin
      gap++;
      @(posedge sys_clk);
    end
    `CHK("imm auto req", 1'b1, status_read_req[q])
    $display("test modes done");
    en = $random(seed) | 32'h1;
    wr(dbi_pkg::FIFO_IRQ_EN_OFS, en);
    fifo_below_limit <= ~en;
    fifo_empty <= en & -en;
    repeat (2) @(posedge sys_clk);
    rd_chk("fifo cause", dbi_pkg::FIFO_IRQ_STAT_OFS, en & -en);
    rd_chk("fifo flag", dbi_pkg::IRQ_STAT_OFS, qbit(dbi_pkg::STAT_FIFO_BIT, 0));
    irq_chk(1'b1);
    fifo_empty <= 32'h0;
    irq_chk(1'b0);
    rd_chk("fifo clear", dbi_pkg::IRQ_STAT_OFS, 32'h0);
    $display("test fifo done");
    finish_test();
  end
endmodule
`default_nettype wire
